// ===== dv/eif_pin_model.sv
// Purpose: external interrupt pins driven toward the filter
// Assumes: levels requested on the system clock
// Notes: order of bits is {c, seven, six}
`timescale 1ns/100ps
`default_nettype none
module eif_pin_model (
  // clock
  input wire logic clk_i,
  // requested levels
  input wire logic [2:0] lvl_i,
  // pins
  output logic [2:0] pins_o
);
  initial pins_o = 3'h0;
  // levels move only on edges, so no pulse is shorter than a clock
  always @(posedge clk_i) begin
    pins_o <= lvl_i;
  end
endmodule
`default_nettype wire

// ===== dv/eif_top_asserts.sv
// Purpose: port-level checks of the interrupt glitch filter
// Assumes: bound to eif_top; control registers shadowed from writes
// Notes: timing checks watch input six only, to keep helpers small
`timescale 1ns/100ps
`default_nettype none
module eif_top_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // pins and power mode
  input wire logic ext_irq_input_c_i,
  input wire logic ext_irq_input_seven_i,
  input wire logic ext_irq_input_six_i,
  input wire logic stop_release_i,
  // forwarded levels
  input wire logic ext_irq_c_o,
  input wire logic ext_irq_seven_o,
  input wire logic ext_irq_six_o
);
  logic [2:0] en_q;
  logic [2:0] sel_q;
  logic six_q;
  logic [15:0] run_q;
  logic [15:0] quiet_q;
  wire logic [2:0] in_w = {ext_irq_input_c_i, ext_irq_input_seven_i, ext_irq_input_six_i};
  wire logic [2:0] out_w = {ext_irq_c_o, ext_irq_seven_o, ext_irq_six_o};
  wire logic [15:0] per_w = 16'h1 << sel_q;
  ////////////////////////////////////////
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q <= 3'h0;
      sel_q <= 3'h0;
    end else if (wr_i && addr_i == 8'h04) begin
      en_q <= wdata_i[2:0];
    end else if (wr_i && addr_i == 8'h00) begin
      sel_q <= wdata_i[2:0];
    end
  end
  // quiet restarts on any write or stop release, so no check sees a mode change
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      six_q <= 1'b0;
      run_q <= 16'h0;
      quiet_q <= 16'h0;
    end else begin
      six_q <= ext_irq_input_six_i;
      run_q <= (ext_irq_input_six_i != six_q) ? 16'h0 : run_q + {15'h0, ~&run_q};
      quiet_q <= (wr_i || stop_release_i) ? 16'h0 : quiet_q + {15'h0, ~&quiet_q};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  chk_rdata_idle:
    assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata outside slot");
  chk_rdata_high:
    assert property (rdata_o[31:7] == 25'h0) else $error("rdata high bits set");
  chk_enable_readback:
    assert property ($past(rd_i && addr_i == 8'h04) |-> rdata_o == {29'h0, en_q})
      else $error("enable readback wrong");
  chk_select_readback:
    assert property ($past(rd_i && addr_i == 8'h00) |-> rdata_o == {29'h0, sel_q})
      else $error("select readback wrong");
  chk_bypass_raw:
    assert property (quiet_q > 16'h5 |-> ((out_w ^ $past(in_w, 2)) & ~en_q) == 3'h0)
      else $error("bypass path wrong");
  // bounds are exact for the raw, filter and output stages, so one tick early or late shows
  chk_reject_short:
    assert property (en_q[0] && quiet_q > 16'h9 * per_w && $changed(ext_irq_six_o)
      |-> $past(run_q, 3) + 16'h1 >= 16'h7 * per_w) else $error("short level taken");
  chk_accept_long:
    assert property (en_q[0] && sel_q != 3'h0 && quiet_q > 16'h9 * per_w
      && run_q > 16'h8 * per_w |-> ext_irq_six_o == six_q)
      else $error("long level not taken");
  chk_frozen_hold:
    assert property (en_q[0] && sel_q == 3'h0 && quiet_q > 16'h3 |-> $stable(ext_irq_six_o))
      else $error("filter moved while stopped");
  cover property (en_q[0] && $rose(ext_irq_six_o));
  cover property (sel_q == 3'h7 && $fell(ext_irq_six_o));
  cover property (stop_release_i && en_q == 3'h0);
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: directed test of the interrupt glitch filter
// Assumes: 10 MHz clock; every filter clock code is walked
// Notes: pins follow lvl one clock later through the pin model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic stop_release_i = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [2:0] pins;
  logic [31:0] rdata_o;
  logic [2:0] outs;
  logic [2:0] any_v;
  logic [2:0] all_v;
  logic [2:0] fin_v;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int p;
  always #50 clk_i = ~clk_i;
  eif_pin_model PINS (.clk_i(clk_i), .lvl_i(lvl), .pins_o(pins));
  eif_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_input_c_i(pins[2]),
    .ext_irq_input_seven_i(pins[1]), .ext_irq_input_six_i(pins[0]),
    .stop_release_i(stop_release_i), .ext_irq_c_o(outs[2]),
    .ext_irq_seven_o(outs[1]), .ext_irq_six_o(outs[0]));
  ////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  task automatic seq(input logic [2:0] a, input int na, input logic [2:0] b, input int nb);
    any_v = 3'h0;
    all_v = 3'h7;
    for (int i = 0; i < na + nb; i++) begin
      lvl <= (i < na) ? a : b;
      @(negedge clk_i);
      any_v = any_v | outs;
      all_v = all_v & outs;
      fin_v = outs;
      @(posedge clk_i);
    end
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    wr_reg(8'h00, 32'hFFFFFFFF);
    rd_chk(8'h00, 32'h7);
    wr_reg(8'h04, 32'hFFFFFFFF);
    rd_chk(8'h04, 32'h7);
    rd_chk(8'h0C, 32'h0);
    for (int s = 1; s < 8; s++) begin
      p = 1 << s;
      wr_reg(8'h04, 32'h0);
      wr_reg(8'h00, s);
      rd_chk(8'h00, s);
      wr_reg(8'h04, 32'h1);
      seq(3'h7, 6 * p, 3'h0, 4 * p);
      chk(any_v[0], 1'b0);
      chk(any_v[2:1], 2'h3);
      seq(3'h1, 10 * p, 3'h1, 4);
      chk(fin_v[0], 1'b1);
      seq(3'h0, 6 * p, 3'h1, 4 * p);
      chk(all_v[0], 1'b1);
      seq(3'h0, 10 * p, 3'h0, 4);
      chk(fin_v[0], 1'b0);
    end
    wr_reg(8'h04, 32'h0);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h04, 32'h1);
    seq(3'h1, 40, 3'h0, 8);
    chk(any_v[0], 1'b0);
    wr_reg(8'h04, 32'h0);
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h04, 32'h1);
    seq(3'h1, 40, 3'h1, 2);
    chk(fin_v[0], 1'b1);
    wr_reg(8'h04, 32'h0);
    wr_reg(8'h00, 32'h0);
    stop_release_i <= 1'b1;
    @(posedge clk_i);
    stop_release_i <= 1'b0;
    wr_reg(8'h00, 32'h1);
    // the stop release has wiped the filter before its enable goes up
    wr_reg(8'h04, 32'h1);
    seq(3'h1, 4, 3'h1, 0);
    chk(fin_v[0], 1'b0);
    seq(3'h1, 30, 3'h1, 0);
    chk(fin_v[0], 1'b1);
    rd_chk(8'h08, 32'h11);
    wr_reg(8'h08, 32'hFFFFFFFF);
    rd_chk(8'h08, 32'h11);
    wrap_up();
  end
endmodule
bind eif_top eif_top_asserts u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ext_irq_input_c_i(ext_irq_input_c_i), .ext_irq_input_seven_i(ext_irq_input_seven_i),
  .ext_irq_input_six_i(ext_irq_input_six_i), .stop_release_i(stop_release_i),
  .ext_irq_c_o(ext_irq_c_o), .ext_irq_seven_o(ext_irq_seven_o), .ext_irq_six_o(ext_irq_six_o));
`default_nettype wire

// ===== inc/eif_pkg.sv
// Purpose: shared constants for the external interrupt glitch filter
// Assumes: 32-bit register port, byte addresses, system clock 10 MHz
// Notes: all offsets, reset values and counts live here
package eif_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // number of filtered inputs and their enable bit positions
  localparam int unsigned CH_N = 3;
  localparam int unsigned EN_BIT_SIX = 0;
  localparam int unsigned EN_BIT_SEVEN = 1;
  localparam int unsigned EN_BIT_C = 2;

  // status register field positions
  localparam int unsigned STAT_FWD_LSB = 0;
  localparam int unsigned STAT_RAW_LSB = 4;

  // clock-select field
  localparam int unsigned SEL_W = 3;
  localparam int unsigned DIV_W = 7;

  typedef enum logic [2:0] {
    EIF_CKS_STOP = 3'b000,
    EIF_CKS_DIV2 = 3'b001,
    EIF_CKS_DIV4 = 3'b010,
    EIF_CKS_DIV8 = 3'b011,
    EIF_CKS_DIV16 = 3'b100,
    EIF_CKS_DIV32 = 3'b101,
    EIF_CKS_DIV64 = 3'b110,
    EIF_CKS_DIV128 = 3'b111
  } eif_cks_type;

  // reset values
  localparam logic [SEL_W-1:0] RST_CLOCK_SEL = 3'h0;
  localparam logic [CH_N-1:0] RST_ENABLE = 3'h0;

  // filter-clock ticks a new level must survive before it is taken
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] ACCEPT_TICKS = 4'h8;

  // divider wrap mask for a clock-select code: 2**code - 1
  function automatic logic [DIV_W-1:0] div_mask(input logic [SEL_W-1:0] sel);
    logic [DIV_W:0] one_hot;
    one_hot = 8'h01 << sel;
    div_mask = one_hot[DIV_W-1:0] - 7'h01;
  endfunction

endpackage

// ===== inc/eif_tick_if.sv
// Purpose: carries the filter-clock tick from the divider to the channels
// Assumes: single system clock domain
// Notes: tick is a one-cycle pulse per filter-clock period
`timescale 1ns/100ps
`default_nettype none
interface eif_tick_if;
  logic tick;

  modport src (
    output tick
  );

  modport snk (
    input tick
  );
endinterface
`default_nettype wire

// ===== src/eif_chan.sv
// Purpose: one glitch filter channel
// Assumes: raw input already registered on the system clock
// Notes: a level is taken after ACCEPT_TICKS ticks with no break
`timescale 1ns/100ps
`default_nettype none
module eif_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // input and control
  input wire logic raw_i,
  input wire logic clr_i,
  eif_tick_if.snk tick_if,
  // result
  output logic state_o
);

  logic [eif_pkg::CNT_W-1:0] cnt_q;

  // any return to the held level restarts the count, in both directions
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      state_o <= 1'b0;
    end else if (clr_i) begin
      cnt_q <= '0;
      state_o <= 1'b0;
    end else if (raw_i == state_o) begin
      cnt_q <= '0;
    end else if (tick_if.tick) begin
      if (cnt_q == eif_pkg::ACCEPT_TICKS - 4'h1) begin
        cnt_q <= '0;
        state_o <= raw_i;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/eif_div.sv
// Purpose: divides the system clock into filter-clock ticks
// Assumes: select changed only while every filter is disabled
// Notes: code zero holds the divider and gives no ticks
`timescale 1ns/100ps
`default_nettype none
module eif_div (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic [eif_pkg::SEL_W-1:0] sel_i,
  // tick out
  eif_tick_if.src tick_if
);

  logic [eif_pkg::DIV_W-1:0] cnt_q;
  logic [eif_pkg::DIV_W-1:0] mask;

  assign mask = eif_pkg::div_mask(sel_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (sel_i == eif_pkg::EIF_CKS_STOP) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // one tick each 2**sel system clocks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_if.tick <= 1'b0;
    end else begin
      tick_if.tick <= (sel_i != eif_pkg::EIF_CKS_STOP) && ((cnt_q & mask) == mask);
    end
  end

endmodule
`default_nettype wire

// ===== src/eif_top.sv
// Purpose: glitch filter for three external interrupt inputs
// Assumes: inputs synchronous to clk_i; stop release given as a pulse
// Notes: edge and level detection sit downstream, not here
//
// Behaviour
// - select field: 000 stops filter clock, 001..111 divide by 2..128
// - enable bit 2 input c, bit 1 input seven, bit 0 input six
// - disabled input forwards raw level; its filter cleared on stop release
// - level under 7 filter periods rejected, over 8 periods accepted
// - filter counts how long the input held its level in ticks
// - both high and low glitches are suppressed
// - each forwarded signal goes on to clock-generator detection
// - filtering only in normal and idle modes; no clock in stop
// - pulses under one system clock need not be removed
`timescale 1ns/100ps
`default_nettype none
module eif_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [eif_pkg::ADDR_W-1:0] addr_i,
  input wire logic [eif_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [eif_pkg::DATA_W-1:0] rdata_o,
  // external interrupt inputs
  input wire logic ext_irq_input_c_i,
  input wire logic ext_irq_input_seven_i,
  input wire logic ext_irq_input_six_i,
  // power mode
  input wire logic stop_release_i,
  // to clock-generator detection
  output logic ext_irq_c_o,
  output logic ext_irq_seven_o,
  output logic ext_irq_six_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  ////////////////////////////////////////////////////////////////////////

  logic rst_meta_q;
  logic rst_n_q;

  // assert at once, release two clocks later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode
  ////////////////////////////////////////////////////////////////////////

  logic hit_clock;
  logic hit_enable;
  logic hit_status;

  assign hit_clock = (addr_i == eif_pkg::OFS_CLOCK_CTRL);
  assign hit_enable = (addr_i == eif_pkg::OFS_ENABLE_CTRL);
  assign hit_status = (addr_i == eif_pkg::OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////
  // control registers
  ////////////////////////////////////////////////////////////////////////

  logic [eif_pkg::SEL_W-1:0] clock_sel_q;
  logic [eif_pkg::CH_N-1:0] enable_q;

  // a select change with filters on is not refused; the channels simply
  // see a shifted tick phase, which the software sequence avoids
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clock_sel_q <= eif_pkg::RST_CLOCK_SEL;
    end else if (wr_i && hit_clock) begin
      clock_sel_q <= wdata_i[eif_pkg::SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enable_q <= eif_pkg::RST_ENABLE;
    end else if (wr_i && hit_enable) begin
      enable_q <= wdata_i[eif_pkg::CH_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input sampling
  ////////////////////////////////////////////////////////////////////////

  logic [eif_pkg::CH_N-1:0] raw_q;

  // sampled once per system clock: a pulse between two edges is missed
  // or caught whole, so it cannot be filtered reliably
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      raw_q <= '0;
    end else begin
      raw_q[eif_pkg::EN_BIT_C] <= ext_irq_input_c_i;
      raw_q[eif_pkg::EN_BIT_SEVEN] <= ext_irq_input_seven_i;
      raw_q[eif_pkg::EN_BIT_SIX] <= ext_irq_input_six_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // filter clock
  ////////////////////////////////////////////////////////////////////////

  eif_tick_if tick_bus ();

  // in stop mode clk_i halts, so this divider and the channels freeze
  eif_div u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .sel_i(clock_sel_q),
    .tick_if(tick_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // filter channels
  ////////////////////////////////////////////////////////////////////////

  logic [eif_pkg::CH_N-1:0] flt_state;
  logic [eif_pkg::CH_N-1:0] chan_clr;

  // only a disabled channel is wiped when stop mode ends
  assign chan_clr = {eif_pkg::CH_N{stop_release_i}} & ~enable_q;

  genvar g;
  generate
    for (g = 0; g < eif_pkg::CH_N; g++) begin : g_chan
      eif_chan u_chan (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .raw_i(raw_q[g]),
        .clr_i(chan_clr[g]),
        .tick_if(tick_bus),
        .state_o(flt_state[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // forwarding
  ////////////////////////////////////////////////////////////////////////

  logic [eif_pkg::CH_N-1:0] fwd;

  // bypass adds the same one-cycle delay as the filtered path
  assign fwd = (enable_q & flt_state) | (~enable_q & raw_q);

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_irq_c_o <= 1'b0;
      ext_irq_seven_o <= 1'b0;
      ext_irq_six_o <= 1'b0;
    end else begin
      ext_irq_c_o <= fwd[eif_pkg::EN_BIT_C];
      ext_irq_seven_o <= fwd[eif_pkg::EN_BIT_SEVEN];
      ext_irq_six_o <= fwd[eif_pkg::EN_BIT_SIX];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  ////////////////////////////////////////////////////////////////////////

  logic [eif_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (hit_clock) begin
      rd_mux[eif_pkg::SEL_W-1:0] = clock_sel_q;
    end else if (hit_enable) begin
      rd_mux[eif_pkg::CH_N-1:0] = enable_q;
    end else if (hit_status) begin
      rd_mux[eif_pkg::STAT_FWD_LSB +: eif_pkg::CH_N] =
        {ext_irq_c_o, ext_irq_seven_o, ext_irq_six_o};
      rd_mux[eif_pkg::STAT_RAW_LSB +: eif_pkg::CH_N] = raw_q;
    end
  end

  // data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule
`default_nettype wire
